//--- design/slr_core.v
// setup learn query, setup restore and measurement rerun handling
// assumes a front end that decodes command words into one-cycle strobes and
// passes raw bus bytes with their end flag; the setup store is external
`timescale 1ns/100ps
`include "slr_defs.vh"
module slr_core #(
    parameter ADDR_W = 16
) (
    // clock and reset
    input wire i_ref_clk,
    input wire i_reset_n,
    // decoded commands
    input wire i_rerun_cmd,
    input wire i_learn_query,
    input wire i_restore_cmd,
    // incoming bus bytes
    input wire i_rx_valid,
    input wire [7:0] i_rx_data,
    input wire i_rx_end,
    output wire o_rx_ready,
    // outgoing bus bytes
    output wire o_tx_valid,
    output wire [7:0] o_tx_data,
    output wire o_tx_end,
    input wire i_tx_ready,
    // setup store
    input wire [ADDR_W-1:0] i_setup_len,
    output reg [ADDR_W-1:0] o_setup_addr,
    input wire [7:0] i_setup_rdata,
    output reg o_setup_we,
    output reg [7:0] o_setup_wdata,
    output reg o_setup_commit,
    output reg o_setup_abort,
    // measurement side
    output reg o_meas_restart,
    output reg o_clear_cumulative,
    output reg o_clear_error_queue,
    output reg o_restore_error,
    output wire o_busy
);
    localparam S_IDLE = 7'h01;
    localparam S_TERM = 7'h02;
    localparam S_HASH = 7'h04;
    localparam S_CNT = 7'h08;
    localparam S_LEN = 7'h10;
    localparam S_DATA = 7'h20;
    localparam S_LEARN = 7'h40;
    reg [6:0] state;
    reg [6:0] next_state;
    reg [3:0] digits;
    reg [ADDR_W-1:0] length;
    reg [ADDR_W-1:0] index;
    reg [3:0] phase;
    reg cr_seen;
    reg wait_rd;
    reg [8:0] gen_word;
    reg gen_valid;
    wire buf_ready;
    wire [8:0] buf_word;
    wire rx_take;
    function is_digit;
        input [7:0] ch;
        begin
            is_digit = (ch >= `SLR_CH_ZERO) && (ch <= `SLR_CH_NINE);
        end
    endfunction

    // pick one decimal digit of the learn length, most significant first
    function [7:0] len_char;
        input [ADDR_W-1:0] n;
        input [3:0] pos;
        reg [31:0] v;
        integer k;
        begin
            v = n;
            for (k = 0; k < 5; k = k + 1) begin
                if (k < 5 - pos) begin
                    v = v / 10;
                end
            end
            v = v % 10;
            len_char = `SLR_CH_ZERO + v[7:0];
        end
    endfunction

    assign rx_take = i_rx_valid && o_rx_ready;
    assign o_rx_ready = (state != S_IDLE) && (state != S_LEARN);
    assign o_busy = (state != S_IDLE);
    assign o_tx_data = buf_word[7:0];
    assign o_tx_end = buf_word[8];
    // =====================================================
    // learn answer buffer
    // learn stream shape
    slr_skid #(
        .WIDTH(9)
    ) u_buf (
        .i_ref_clk(i_ref_clk),
        .i_reset_n(i_reset_n),
        .i_in_valid(gen_valid),
        .i_in_data(gen_word),
        .o_in_ready(buf_ready),
        .o_out_valid(o_tx_valid),
        .o_out_data(buf_word),
        .i_out_ready(i_tx_ready)
    );
    // =====================================================
    // next state
    always @* begin
        next_state = state;
        case (state)
            S_IDLE: begin
                if (i_learn_query) begin
                    next_state = S_LEARN;
                end else if (i_restore_cmd) begin
                    next_state = S_TERM;
                end
            end
            S_TERM: begin
                if (rx_take && cr_seen && i_rx_data == `SLR_CH_LF) begin
                    next_state = S_HASH;
                end else if (rx_take && !(!cr_seen &&
                             i_rx_data == `SLR_CH_CR)) begin
                    next_state = S_IDLE;
                end
            end
            S_HASH: begin
                // non block or a new command is refused
                if (rx_take) begin
                    next_state = (i_rx_data == `SLR_CH_HASH) ? S_CNT : S_IDLE;
                end else if (i_learn_query || i_restore_cmd ||
                             i_rerun_cmd) begin
                    next_state = S_IDLE;
                end
            end
            S_CNT: begin
                if (rx_take) begin
                    if (is_digit(i_rx_data) && i_rx_data != `SLR_CH_ZERO) begin
                        next_state = S_LEN;
                    end else begin
                        next_state = S_IDLE;
                    end
                end
            end
            S_LEN: begin
                if (rx_take) begin
                    if (!is_digit(i_rx_data) || i_rx_end) begin
                        next_state = S_IDLE;
                    end else if (digits == 4'h1) begin
                        next_state = S_DATA;
                    end
                end
            end
            S_DATA: begin
                if (rx_take && (i_rx_end || index + 1'b1 == length)) begin
                    next_state = S_IDLE;
                end
            end
            S_LEARN: begin
                if (gen_valid && buf_ready && gen_word[8]) begin
                    next_state = S_IDLE;
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
    end

    // =====================================================
    // datapath
    always @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= S_IDLE;
            digits <= 4'h0;
            length <= {ADDR_W{1'b0}};
            index <= {ADDR_W{1'b0}};
            phase <= 4'h0;
            cr_seen <= 1'b0;
            wait_rd <= 1'b0;
            gen_word <= 9'h000;
            gen_valid <= 1'b0;
            o_setup_addr <= {ADDR_W{1'b0}};
            o_setup_we <= 1'b0;
            o_setup_wdata <= 8'h00;
            o_setup_commit <= 1'b0;
            o_setup_abort <= 1'b0;
            o_meas_restart <= 1'b0;
            o_clear_cumulative <= 1'b0;
            o_clear_error_queue <= 1'b0;
            o_restore_error <= 1'b0;
        end else begin
            state <= next_state;
            o_setup_we <= 1'b0;
            o_setup_commit <= 1'b0;
            o_setup_abort <= 1'b0;
            o_restore_error <= 1'b0;
            o_meas_restart <= i_rerun_cmd;
            o_clear_cumulative <= i_rerun_cmd;
            o_clear_error_queue <= i_rerun_cmd;
            // no key queue or data value port is touched here
            if (gen_valid && buf_ready) begin
                gen_valid <= 1'b0;
            end
            case (state)
                S_IDLE: begin
                    cr_seen <= 1'b0;
                    phase <= 4'h0;
                    index <= {ADDR_W{1'b0}};
                    length <= {ADDR_W{1'b0}};
                    wait_rd <= 1'b0;
                end
                S_TERM: begin
                    if (rx_take) begin
                        cr_seen <= (i_rx_data == `SLR_CH_CR) && !cr_seen;
                        if (next_state == S_IDLE) begin
                            o_restore_error <= 1'b1;
                        end
                    end
                end
                S_HASH, S_CNT: begin
                    if (rx_take) begin
                        digits <= i_rx_data[3:0];
                    end
                    if (next_state == S_IDLE) begin
                        o_restore_error <= 1'b1;
                    end
                end
                S_LEN: begin
                    if (rx_take) begin
                        length <= length * {{(ADDR_W-4){1'b0}}, 4'ha} +
                            {{(ADDR_W-4){1'b0}}, i_rx_data[3:0]};
                        digits <= digits - 4'h1;
                        if (next_state == S_IDLE) begin
                            o_restore_error <= 1'b1;
                        end
                    end
                end
                S_DATA: begin
                    if (rx_take) begin
                        o_setup_we <= 1'b1;
                        o_setup_addr <= index;
                        o_setup_wdata <= i_rx_data;
                        index <= index + 1'b1;
                        // the end flag must sit on the last counted byte
                        if (i_rx_end && index + 1'b1 == length) begin
                            o_setup_commit <= 1'b1;
                        end else if (i_rx_end || index + 1'b1 == length) begin
                            o_setup_abort <= 1'b1;
                            o_restore_error <= 1'b1;
                        end
                    end
                end
                S_LEARN: begin
                    if (!gen_valid || buf_ready) begin
                        if (phase == 4'h0) begin
                            gen_word <= {1'b0, `SLR_CH_HASH};
                            gen_valid <= 1'b1;
                            phase <= 4'h1;
                        end else if (phase == 4'h1) begin
                            gen_word <= {1'b0, `SLR_LEARN_DIGIT_CH};
                            gen_valid <= 1'b1;
                            phase <= 4'h2;
                        end else if (phase < 4'h2 + `SLR_LEARN_DIGITS) begin
                            gen_word <= {(i_setup_len == {ADDR_W{1'b0}}) &&
                                (phase == 4'h1 + `SLR_LEARN_DIGITS),
                                len_char(i_setup_len, phase - 4'h2)};
                            gen_valid <= 1'b1;
                            phase <= phase + 4'h1;
                            o_setup_addr <= {ADDR_W{1'b0}};
                            wait_rd <= 1'b1;
                        end else if (wait_rd) begin
                            gen_valid <= 1'b0;
                            wait_rd <= 1'b0;
                        end else begin
                            gen_word <= {(index + 1'b1 == i_setup_len),
                                         i_setup_rdata};
                            gen_valid <= 1'b1;
                            index <= index + 1'b1;
                            o_setup_addr <= index + 1'b1;
                            wait_rd <= 1'b1;
                        end
                    end
                end
                default: begin
                    cr_seen <= 1'b0;
                end
            endcase
        end
    end
endmodule // slr_core

//--- design/slr_defs.vh
// constants for the setup learn and restart command block
// assumes a byte-wide parsed command stream from the bus front end
// Notes on behaviour
// - the rerun command restarts measurement and drops cumulative results.
// - the rerun command also empties the error queue.
// - the rerun command leaves the pending key queue alone.
// - the rerun command leaves user entered data values alone.
// - the learn query sends the whole current setup as a binary block.
// - the learn block has exactly the format that the restore accepts; for an empty setup it ends on a length digit, which the restore refuses.
// - anything other than a block after the restore terminator is an error.
// - a block is hash, nonzero digit, length field, data with end on last.
// - the digit after the hash counts the digits of the length field.
// - the length field is an unsigned decimal count of payload bytes.
// - the learn answer always uses digit 6 and a six digit length.
// - a valid restore block rewrites every setting it carries.
`ifndef SLR_DEFS_VH
`define SLR_DEFS_VH
// =====================================================
// characters and the learn length digit count
`define SLR_CH_HASH 8'h23
`define SLR_CH_ZERO 8'h30
`define SLR_CH_NINE 8'h39
`define SLR_CH_CR 8'h0d
`define SLR_CH_LF 8'h0a
`define SLR_LEARN_DIGITS 3'h6
`define SLR_LEARN_DIGIT_CH 8'h36
// =====================================================
// buffer geometry
`define SLR_BUF_DEPTH 2
`endif

//--- design/slr_skid.v
// two-entry buffer between the learn answer source and the bus sender
// assumes one clock, sender may stall at any time
`timescale 1ns/100ps
module slr_skid #(
    parameter WIDTH = 9
) (
    // clock and reset
    input wire i_ref_clk,
    input wire i_reset_n,
    // fill side
    input wire i_in_valid,
    input wire [WIDTH-1:0] i_in_data,
    output wire o_in_ready,
    // drain side
    output wire o_out_valid,
    output wire [WIDTH-1:0] o_out_data,
    input wire i_out_ready
);
    reg [WIDTH-1:0] mem [0:1];
    reg wr_ptr;
    reg rd_ptr;
    reg [1:0] count;
    wire push;
    wire pop;
    assign o_in_ready = (count != 2'h2);
    assign o_out_valid = (count != 2'h0);
    assign o_out_data = mem[rd_ptr];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    always @(posedge i_ref_clk) begin
        if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end
    always @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            if (push && !pop) begin
                count <= count + 2'h1;
            end else if (pop && !push) begin
                count <= count - 2'h1;
            end
        end
    end
endmodule // slr_skid

//--- verification/slr_core_checker.sv
// concurrent checks on the ports of the setup learn and restart block
// assumes one clock domain and binding onto slr_core
`timescale 1ns/100ps
module slr_core_checker (
    // clock and reset
    input logic i_ref_clk,
    input logic i_reset_n,
    // watched inputs
    input logic i_rerun_cmd,
    input logic i_learn_query,
    input logic i_tx_ready,
    // watched outputs
    input logic o_tx_valid,
    input logic [7:0] o_tx_data,
    input logic o_tx_end,
    input logic o_setup_we,
    input logic o_setup_commit,
    input logic o_restore_error,
    input logic o_meas_restart,
    input logic o_clear_cumulative,
    input logic o_clear_error_queue,
    input logic o_busy
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);
    // ==========================================
    // learn answer header steps
    sequence s_hash_out;
        o_tx_valid && o_tx_data == 8'h23;
    endsequence
    sequence s_six_out;
        o_tx_valid && o_tx_data == 8'h36;
    endsequence
    // ==========================================
    // properties
    chk_rerun_restart: assert property (
        i_rerun_cmd |=> o_meas_restart && o_clear_cumulative)
        else $error("rerun did not restart measurement");
    chk_rerun_errq: assert property (
        i_rerun_cmd |=> o_clear_error_queue)
        else $error("rerun did not clear error queue");
    chk_clear_cause: assert property (
        o_clear_error_queue |-> $past(i_rerun_cmd))
        else $error("error queue cleared without rerun");
    chk_rerun_nowrite: assert property (
        i_rerun_cmd && !o_busy |=> !o_setup_we)
        else $error("rerun touched stored setup");
    chk_learn_hash: assert property (
        i_learn_query && !o_busy |-> ##[1:4] s_hash_out)
        else $error("learn answer did not open with hash");
    chk_learn_six: assert property (
        o_tx_valid && i_tx_ready && o_tx_data == 8'h23 |=> ##[0:8] s_six_out)
        else $error("count digit after hash is not six");
    chk_tx_hold: assert property (
        o_tx_valid && !i_tx_ready |=>
        o_tx_valid && $stable(o_tx_data) && $stable(o_tx_end))
        else $error("stalled answer byte changed");
    chk_commit_clean: assert property (
        o_setup_commit |-> o_setup_we && !o_restore_error)
        else $error("commit without final write");
    chk_err_idle: assert property (
        o_restore_error |-> ##[0:2] !o_busy)
        else $error("restore error did not return to idle");
endmodule // slr_core_checker

bind slr_core slr_core_checker u_chk (.i_ref_clk, .i_reset_n,
    .i_rerun_cmd, .i_learn_query, .i_tx_ready, .o_tx_valid, .o_tx_data,
    .o_tx_end, .o_setup_we, .o_setup_commit, .o_restore_error,
    .o_meas_restart, .o_clear_cumulative, .o_clear_error_queue, .o_busy);

//--- verification/slr_store_model.sv
// behavioural setup store on the far side of the block
// assumes synchronous read, data one cycle after the address
`timescale 1ns/100ps
module slr_store_model (
    // clock
    input logic i_ref_clk,
    // access
    input logic [15:0] i_addr,
    input logic i_we,
    input logic [7:0] i_wdata,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [0:255];
    // restored bytes kept, read back a cycle late
    always @(posedge i_ref_clk) begin
        if (i_we) begin
            mem[i_addr[7:0]] <= i_wdata;
        end
        o_rdata <= mem[i_addr[7:0]];
    end
endmodule // slr_store_model

//--- verification/tb_top.sv
// self-checking bench for the setup learn and restart block
// assumes the store model answers the setup store port
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
$display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb_top;
    logic i_ref_clk = 0, i_reset_n = 0, i_rerun_cmd = 0, i_learn_query = 0;
    logic i_restore_cmd = 0, i_rx_valid = 0, i_rx_end = 0, i_tx_ready = 0;
    logic [7:0] i_rx_data = 8'h00, i_setup_rdata, o_tx_data, o_setup_wdata;
    logic [15:0] i_setup_len = 16'h0000, o_setup_addr;
    logic o_rx_ready, o_tx_valid, o_tx_end, o_setup_we, o_setup_commit;
    logic o_setup_abort, o_meas_restart, o_clear_cumulative, o_busy;
    logic o_clear_error_queue, o_restore_error;
    logic [7:0] lfsr = 8'h07, tmp;
    logic [7:0] exp_d[$];
    logic [8:0] txq[$];
    int fails = 0, n_compared = 0, n_we = 0, n_commit = 0, n_err = 0;
    int n_abort = 0, a0;
    logic [7:0] blk[7] = '{8'h0d, 8'h0a, 8'h23, 8'h31, 8'h32, 8'h55, 8'h5a};
    int stall = 0, nd, len, e0, w0, c0;
    logic [31:0] bad[4] = '{32'h0d230000, 32'h0d0a4100, 32'h0d0a2330,
        32'h0d0a233a};
    int cnt[4] = '{2, 3, 4, 4};
    initial begin
        forever #25 i_ref_clk = ~i_ref_clk;
    end
    slr_core #(.ADDR_W(16)) dut (.i_ref_clk, .i_reset_n, .i_rerun_cmd,
        .i_learn_query, .i_restore_cmd, .i_rx_valid, .i_rx_data, .i_rx_end,
        .o_rx_ready, .o_tx_valid, .o_tx_data, .o_tx_end, .i_tx_ready,
        .i_setup_len, .o_setup_addr, .i_setup_rdata, .o_setup_we,
        .o_setup_wdata, .o_setup_commit, .o_setup_abort, .o_meas_restart,
        .o_clear_cumulative, .o_clear_error_queue, .o_restore_error, .o_busy);
    slr_store_model u_store (.i_ref_clk, .i_addr(o_setup_addr),
        .i_we(o_setup_we), .i_wdata(o_setup_wdata), .o_rdata(i_setup_rdata));
    // ==========================================
    // stimulus helpers
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        return lfsr;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(negedge i_ref_clk);
    endtask
    task automatic wait_idle();
        int k = 0;
        while (o_busy !== 1'b0 && k < 300) begin
            tick(1);
            k++;
        end
        if (k == 300) fails++;
    endtask
    // valid stays up between bytes; the caller drops it after the last
    task automatic send(input logic [7:0] b, input logic e);
        int k = 0;
        i_rx_valid = 1;
        i_rx_data = b;
        i_rx_end = e;
        while (o_rx_ready !== 1'b1 && k < 50) begin
            tick(1);
            k++;
        end
        if (k == 50) fails++;
        tick(1);
    endtask
    // ==========================================
    // observation of the design
    always @(posedge i_ref_clk) begin
        n_we += o_setup_we;
        n_commit += o_setup_commit;
        n_err += o_restore_error;
        n_abort += o_setup_abort;
        if (o_tx_valid && i_tx_ready) txq.push_back({o_tx_end, o_tx_data});
    end
    // a long stall first lets the answer buffer fill and refuse
    always @(negedge i_ref_clk) begin
        tmp = rnd();
        i_tx_ready <= (stall == 0) && (tmp[0] | tmp[1]);
        if (stall > 0) stall--;
    end
    // ==========================================
    // scenarios
    task automatic restore_ok();
        int i;
        w0 = n_we;
        c0 = n_commit;
        e0 = n_err;
        a0 = n_abort;
        i_restore_cmd = 1;
        tick(1);
        i_restore_cmd = 0;
        send(8'h0d, 0);
        send(8'h0a, 0);
        send(8'h23, 0);
        send(8'(8'h30 + nd), 0);
        for (i = 1; i < nd; i++) send(8'h30, 0);
        send(8'(8'h30 + len), 0);
        for (i = 0; i < len; i++) send(exp_d[i], i == len - 1);
        i_rx_valid = 0;
        wait_idle();
        tick(2);
        `CHK("bytes written", w0 + len, n_we)
        `CHK("commits", c0 + 1, n_commit)
        `CHK("no error", e0, n_err)
        `CHK("no abort", a0, n_abort)
    endtask
    task automatic learn_check();
        int k;
        logic [8:0] want[$];
        want = {9'h023, 9'h036};
        for (k = 5; k >= 0; k--) want.push_back(9'(48 + (len / 10**k) % 10));
        for (k = 0; k < len; k++) want.push_back({k == len - 1, exp_d[k]});
        txq.delete();
        i_setup_len = 16'(len);
        stall = 12;
        i_learn_query = 1;
        tick(1);
        i_learn_query = 0;
        k = 0;
        while (txq.size() < want.size() && k < 500) begin
            tick(1);
            k++;
        end
        `CHK("learn length", want.size(), txq.size())
        foreach (want[j]) if (j < txq.size()) `CHK("learn byte", want[j], txq[j])
        wait_idle();
    endtask
    task automatic wrap_up();
        $display("compared %0d mismatched %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // the whole run needs a few hundred cycles; this leaves ample margin
    initial begin
        repeat (20000) @(posedge i_ref_clk);
        fails++;
        wrap_up();
    end
    initial begin
        tick(6);
        i_reset_n = 1;
        tick(2);
        w0 = n_we;
        i_rerun_cmd = 1;
        tick(1);
        `CHK("restart", 1'b1, o_meas_restart)
        tick(1);
        i_rerun_cmd = 0;
        `CHK("clear cumulative", 1'b1, o_clear_cumulative)
        `CHK("clear errors", 1'b1, o_clear_error_queue)
        tick(1);
        `CHK("restart over", 1'b0, o_meas_restart)
        `CHK("no store write", w0, n_we)
        for (nd = 1; nd <= 3; nd++) begin
            len = 1 + rnd() % 8;
            exp_d.delete();
            repeat (len) exp_d.push_back(rnd() | 8'h80);
            restore_ok();
            learn_check();
        end
        foreach (bad[c]) begin
            e0 = n_err;
            w0 = n_we;
            a0 = n_abort;
            i_restore_cmd = 1;
            tick(1);
            i_restore_cmd = 0;
            for (int i = 0; i < cnt[c]; i++) send(bad[c][31-8*i -: 8], 0);
            i_rx_valid = 0;
            wait_idle();
            tick(2);
            `CHK("error pulse", e0 + 1, n_err)
            `CHK("nothing written", w0, n_we)
            `CHK("no abort", a0, n_abort)
        end
        // a command straight after the terminator
        e0 = n_err;
        txq.delete();
        i_restore_cmd = 1;
        tick(1);
        i_restore_cmd = 0;
        send(8'h0d, 0);
        send(8'h0a, 0);
        i_rx_valid = 0;
        i_learn_query = 1;
        tick(1);
        i_learn_query = 0;
        wait_idle();
        tick(2);
        `CHK("command error", e0 + 1, n_err)
        `CHK("no answer", 0, txq.size())
        // end flag missing on the last byte
        e0 = n_err;
        c0 = n_commit;
        a0 = n_abort;
        i_restore_cmd = 1;
        tick(1);
        i_restore_cmd = 0;
        foreach (blk[i]) send(blk[i], 0);
        i_rx_valid = 0;
        wait_idle();
        tick(2);
        `CHK("abort pulse", a0 + 1, n_abort)
        `CHK("no commit", c0, n_commit)
        `CHK("error on end", e0 + 1, n_err)
        wrap_up();
    end
endmodule // tb_top
